// *** hdl/pcb_pkg.sv ***
// constants for the counter byte read port
package pcb_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned NUM_CNT = 11;
   // counter byte map: counter i high byte at base + 2i, low at +1
   localparam logic [11:0] CNT_BASE = 12'h050;
   localparam logic [11:0] LINE_VIOLATION_COUNT_HIGH = 12'h050;
   localparam logic [11:0] LINE_VIOLATION_COUNT_LOW = 12'h051;
   localparam logic [11:0] CNT_LAST = 12'h065;
   localparam logic [11:0] COUNTER_BYTE_HOLDING = 12'h06C;
   localparam logic [11:0] COUNTER_FREEZE = 12'h06E;
   localparam int unsigned FREEZE_BIT = 0;
   localparam logic [7:0] FREEZE_RESET = 8'h00;
   localparam logic [7:0] HOLD_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   // counter index order
   localparam int unsigned CI_LINE_CODE_VIOLATION = 0;
   localparam int unsigned CI_FRAMING_ERROR = 1;
   localparam int unsigned CI_FAR_END_BLOCK_ERROR = 2;
   localparam int unsigned CI_PARITY_ERROR = 3;
   localparam int unsigned CI_HEADER_CHECK_SINGLE = 4;
   localparam int unsigned CI_HEADER_CHECK_MULTI = 5;
   localparam int unsigned CI_RX_IDLE_CELL = 6;
   localparam int unsigned CI_RX_VALID_CELL = 7;
   localparam int unsigned CI_DISCARDED_CELL = 8;
   localparam int unsigned CI_TX_IDLE_CELL = 9;
   localparam int unsigned CI_TX_VALID_CELL = 10;
endpackage

// *** hdl/pcb_event_counter.sv ***
// one 16-bit clear-on-read event counter
`timescale 1ns/10ps
module pcb_event_counter (
   input wire logic clk, // 40 MHz clock
   input wire logic srst, // synchronous reset, high
   input wire logic inc, // count one event
   input wire logic freeze, // hold count
   input wire logic clr, // clear on read
   output logic [15:0] count // current count
);
   // clear wins over old value but an event in that cycle still counts
   always_ff @(posedge clk) begin
      if (srst) begin
         count <= pcb_pkg::CNT_RESET;
      end else if (clr) begin
         count <= (inc && !freeze) ? 16'h0001 : pcb_pkg::CNT_RESET;
      end else if (inc && !freeze && count != pcb_pkg::CNT_MAX) begin
         count <= count + 16'h0001;
      end
   end
endmodule

// *** hdl/pcb_perf_counter_port.sv ***
// byte-wide host port with clear-on-read counters and holding register
//
// Summary of operation
// - data moves over an 8-bit two-way bus driven on reads, sampled on writes.
// - any even or odd address may be read or written, with no alignment.
// - ordinary registers are one byte, so one access covers one register.
// - both separate-strobe and data-strobe-plus-direction bus styles work.
// - single programmed transfers and bursts with address advance both work.
// - each counter is 16 bits seen as a high byte and a low byte.
// - eleven counters exist for line, framing, block, parity and cell events.
// - reading either byte of a counter clears the whole counter to zero, or to one if an event counts in that same cycle.
// - the line code violation counter high byte is 0x50 and low byte 0x51.
// - reading a counter byte copies its companion byte into 0x6c first.
// - a static select picks data-strobe style when high, two strobes when low.
`timescale 1ns/10ps
module pcb_perf_counter_port (
   input wire logic clk, // 40 MHz clock
   input wire logic srst, // synchronous reset, high
   input wire logic bus_style_select, // 1 data strobe style, 0 two strobes
   input wire logic cs_n, // chip select, low
   input wire logic ale_as, // address latch / address strobe
   input wire logic rd_ds, // read strobe or data strobe, low
   input wire logic wr_rw, // write strobe, or read high / write low
   input wire logic [11:0] addr, // host address
   input wire logic [7:0] data_in, // data bus input side
   output logic [7:0] data_out, // data bus output side
   output logic data_oe, // high while driving data bus
   output logic rdy_n, // ready / transfer acknowledge
   input wire logic [10:0] count_event // one pulse per event, per counter
);
   ////////////////////////////////////////////////////////////////////////
   // address decode helpers
   function automatic logic is_counter(input logic [11:0] a);
      return (a >= pcb_pkg::CNT_BASE) && (a <= pcb_pkg::CNT_LAST);
   endfunction

   function automatic logic [3:0] counter_index(input logic [11:0] a);
      logic [11:0] off;
      off = a - pcb_pkg::CNT_BASE;
      return off[4:1];
   endfunction

   logic rd_act;
   logic wr_act;
   logic rd_act_q;
   logic wr_act_q;
   logic rd_start;
   logic wr_end;
   logic acc_end;
   logic ale_open;
   logic [11:0] addr_lat;
   logic [7:0] wr_data_q;
   logic [7:0] freeze_reg;
   logic [7:0] holding;
   logic [15:0] counts [pcb_pkg::NUM_CNT];
   logic [10:0] clr_vec;
   logic [3:0] rd_idx;
   logic [15:0] rd_cnt;
   logic [7:0] next_data_out;
   logic busy;
   logic done;

   ////////////////////////////////////////////////////////////////////////
   // strobe decode for both bus styles
   always_comb begin
      if (bus_style_select) begin
         rd_act = !cs_n && !rd_ds && wr_rw;
         wr_act = !cs_n && !rd_ds && !wr_rw;
         ale_open = !ale_as;
      end else begin
         rd_act = !cs_n && !rd_ds;
         wr_act = !cs_n && !wr_rw;
         ale_open = ale_as;
      end
   end

   assign rd_start = rd_act && !rd_act_q;
   assign wr_end = wr_act_q && !wr_act;
   assign acc_end = wr_end || (rd_act_q && !rd_act);

   // strobe history for edge detection
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_act_q <= 1'b0;
         wr_act_q <= 1'b0;
      end else begin
         rd_act_q <= rd_act;
         wr_act_q <= wr_act;
      end
   end

   // write data captured while the strobe is low, used at its release
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_data_q <= 8'h00;
      end else if (wr_act) begin
         wr_data_q <= data_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address latch, advancing after each access for bursts
   always_ff @(posedge clk) begin
      if (srst) begin
         addr_lat <= 12'h000;
      end else if (ale_open) begin
         addr_lat <= addr;
      end else if (acc_end) begin
         addr_lat <= addr_lat + 12'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counters
   assign rd_idx = counter_index(addr_lat);
   assign rd_cnt = counts[rd_idx];

   // clear pulse for the counter whose byte is being read
   always_comb begin
      clr_vec = 11'h000;
      if (rd_start && is_counter(addr_lat)) begin
         clr_vec[rd_idx] = 1'b1;
      end
   end

   // eleven 16-bit counters
   genvar gi;
   generate
      for (gi = 0; gi < pcb_pkg::NUM_CNT; gi++) begin : g_cnt
         pcb_event_counter u_cnt (
            .clk(clk),
            .srst(srst),
            .inc(count_event[gi]),
            .freeze(freeze_reg[pcb_pkg::FREEZE_BIT]),
            .clr(clr_vec[gi]),
            .count(counts[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // holding register takes the unread byte of a counter
   always_ff @(posedge clk) begin
      if (srst) begin
         holding <= pcb_pkg::HOLD_RESET;
      end else if (rd_start && is_counter(addr_lat)) begin
         holding <= addr_lat[0] ? rd_cnt[15:8] : rd_cnt[7:0];
      end
   end

   // freeze control register, the only writable byte here
   always_ff @(posedge clk) begin
      if (srst) begin
         freeze_reg <= pcb_pkg::FREEZE_RESET;
      end else if (wr_end && addr_lat == pcb_pkg::COUNTER_FREEZE) begin
         freeze_reg <= wr_data_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data mux, any byte address
   always_comb begin
      next_data_out = pcb_pkg::UNMAPPED_READ;
      if (is_counter(addr_lat)) begin
         // even byte is high, odd is low
         next_data_out = addr_lat[0] ? rd_cnt[7:0] : rd_cnt[15:8];
      end else if (addr_lat == pcb_pkg::COUNTER_BYTE_HOLDING) begin
         next_data_out = holding;
      end else if (addr_lat == pcb_pkg::COUNTER_FREEZE) begin
         next_data_out = freeze_reg;
      end
   end

   // read data loaded once at strobe start so the clear cannot disturb it
   always_ff @(posedge clk) begin
      if (srst) begin
         data_out <= 8'h00;
      end else if (rd_start) begin
         data_out <= next_data_out;
      end
   end

   // bus driven only while a read strobe is active
   always_ff @(posedge clk) begin
      if (srst) begin
         data_oe <= 1'b0;
      end else begin
         data_oe <= rd_act;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // ready: two-strobe style goes low until ready, data-strobe acks low
   assign busy = rd_act || wr_act;
   assign done = (rd_act && rd_act_q) || (wr_act && wr_act_q);

   always_ff @(posedge clk) begin
      if (srst) begin
         rdy_n <= 1'b1;
      end else if (bus_style_select) begin
         rdy_n <= !done;
      end else begin
         rdy_n <= !(busy && !done);
      end
   end
endmodule

// *** tb/pcb_port_chk_sva.sv ***
// checker of host port timing
`timescale 1ns/10ps
module pcb_port_chk (
   input wire logic clk, // clock
   input wire logic srst, // reset
   input wire logic bus_style_select, // style
   input wire logic cs_n, // select
   input wire logic rd_ds, // strobe
   input wire logic wr_rw, // strobe or dir
   input wire logic [7:0] data_out, // data
   input wire logic data_oe, // drive
   input wire logic rdy_n // ready
);
   logic rd_a;
   logic wr_a;
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   // decoded strobes
   assign rd_a = !cs_n && !rd_ds && (!bus_style_select || wr_rw);
   assign wr_a = !cs_n && !wr_rw && (!bus_style_select || !rd_ds);
   chk_reset_quiet: assert property (disable iff (1'b0)
      srst |=> !data_oe && rdy_n && data_out == 8'h00) else $error("reset");
   chk_oe_on: assert property ($rose(rd_a) |=> data_oe)
      else $error("no drive");
   chk_oe_off: assert property ($fell(rd_a) |=> !data_oe)
      else $error("drive late");
   chk_write_no_drive: assert property (wr_a |=> !data_oe)
      else $error("drive on write");
   chk_cs_ignored: assert property (cs_n |=> !data_oe)
      else $error("drive unselected");
   chk_ready_two: assert property
      (!bus_style_select && $rose(rd_a) |=> !rdy_n ##1 rdy_n) else $error("rdy");
   chk_ready_ack: assert property
      (bus_style_select && $rose(rd_a) |=> rdy_n ##1 !rdy_n) else $error("ack");
   chk_ready_idle: assert property
      (!(rd_a || wr_a) [*2] |=> rdy_n) else $error("ready idle");
   chk_data_stands: assert property
      (!$rose(rd_a) |=> $stable(data_out)) else $error("data moved");
   cover property ($rose(rd_a) && bus_style_select);
   cover property ($rose(rd_a) && !bus_style_select);
   cover property ($rose(wr_a));
endmodule
bind pcb_perf_counter_port pcb_port_chk u_chk (.clk(clk), .srst(srst),
   .bus_style_select(bus_style_select), .cs_n(cs_n), .rd_ds(rd_ds),
   .wr_rw(wr_rw), .data_out(data_out), .data_oe(data_oe), .rdy_n(rdy_n));

// *** tb/pcb_host.sv ***
// host processor model on the byte bus
`timescale 1ns/10ps
module pcb_host (
   input wire logic clk, // clock
   input wire logic sty, // bus style
   input wire logic [7:0] data_out, // read data
   input wire logic rdy_n, // ready
   output logic cs_n, // select
   output logic ale_as, // latch
   output logic rd_ds, // strobe
   output logic wr_rw, // strobe or dir
   output logic [11:0] addr, // address
   output logic [7:0] data_in // write data
);
   // idle bus
   initial begin
      cs_n = 1'b1;
      ale_as = 1'b0;
      rd_ds = 1'b1;
      wr_rw = 1'b1;
      addr = 12'h000;
      data_in = 8'h00;
   end
   // one access; lat low continues a burst
   task automatic acc(input logic w, input logic lat, input logic [11:0] a,
      input logic [7:0] wd, output logic [7:0] q);
      int n;
      if (lat) begin
         @(posedge clk);
         cs_n <= 1'b0;
         ale_as <= !sty;
         addr <= a;
         @(posedge clk);
         ale_as <= sty;
      end
      @(posedge clk);
      addr <= ~a;
      data_in <= wd;
      wr_rw <= !w;
      rd_ds <= !(sty || !w);
      n = 0;
      // ready is looked at between edges, the strobe dropped on the next one
      @(posedge clk);
      @(negedge clk);
      while (rdy_n !== !sty && n < 20) begin
         @(negedge clk);
         n++;
      end
      if (n >= 20) begin
         $display("Error ready expected %b seen %b", !sty, rdy_n);
         tb_top.n_fail++;
      end
      q = data_out;
      @(posedge clk);
      rd_ds <= 1'b1;
      wr_rw <= 1'b1;
      data_in <= ~wd;
      @(posedge clk);
   endtask
endmodule

// *** tb/tb_top.sv ***
// testbench of the counter byte port
`timescale 1ns/10ps
`define CHK(e, g) begin n_compared++; if ((g) !== (e)) begin \
   $display("Error read %h expected %h seen %h", a, e, g); n_fail++; end end
module tb_top;
   logic clk, srst, sty, cs_n, ale_as, rd_ds, wr_rw, data_oe, rdy_n;
   logic [10:0] ev;
   logic [11:0] addr;
   logic [7:0] data_in, data_out, q;
   int n_fail = 0;
   int n_compared = 0;
   pcb_perf_counter_port u_dut (.clk(clk), .srst(srst), .bus_style_select(sty),
      .cs_n(cs_n), .ale_as(ale_as), .rd_ds(rd_ds), .wr_rw(wr_rw), .addr(addr),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .rdy_n(rdy_n), .count_event(ev));
   pcb_host u_host (.clk(clk), .sty(sty), .data_out(data_out), .rdy_n(rdy_n),
      .cs_n(cs_n), .ale_as(ale_as), .rd_ds(rd_ds), .wr_rw(wr_rw),
      .addr(addr), .data_in(data_in));
   task automatic rd(input logic lat, input logic [11:0] a, input logic [7:0] e);
      u_host.acc(1'b0, lat, a, 8'h00, q);
      `CHK(e, q)
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      u_host.acc(1'b1, 1'b1, a, d, q);
   endtask
   // every counter gets i+2 events, high byte read then holding
   task automatic t_map;
      rd(1'b1, pcb_pkg::COUNTER_BYTE_HOLDING, pcb_pkg::HOLD_RESET);
      for (int j = 0; j < 13; j++) begin
         @(posedge clk);
         for (int i = 0; i < 11; i++) ev[i] <= (j < i + 2);
      end
      for (int i = 0; i < 11; i++) begin
         rd(1'b1, pcb_pkg::CNT_BASE + 12'(2 * i), 8'h00);
         rd(1'b1, pcb_pkg::COUNTER_BYTE_HOLDING, 8'(i + 2));
      end
   endtask
   // low byte first, holding survives its own read
   task automatic t_low_first;
      @(posedge clk);
      ev <= 11'h001;
      repeat (259) @(posedge clk);
      ev <= 11'h000;
      rd(1'b1, pcb_pkg::LINE_VIOLATION_COUNT_LOW, 8'h03);
      rd(1'b1, pcb_pkg::COUNTER_BYTE_HOLDING, 8'h01);
      rd(1'b1, pcb_pkg::COUNTER_BYTE_HOLDING, 8'h01);
      rd(1'b1, pcb_pkg::LINE_VIOLATION_COUNT_HIGH, 8'h00);
   endtask
   // data strobe style, burst into the next counter, write readback
   task automatic t_burst;
      sty <= 1'b1;
      ev <= 11'h018;
      repeat (5) @(posedge clk);
      ev <= 11'h010;
      @(posedge clk);
      ev <= 11'h000;
      rd(1'b1, pcb_pkg::CNT_BASE + 12'h007, 8'h05);
      rd(1'b0, 12'h000, 8'h00);
      rd(1'b1, pcb_pkg::COUNTER_BYTE_HOLDING, 8'h06);
      wr(pcb_pkg::COUNTER_FREEZE, 8'h01);
      rd(1'b1, pcb_pkg::COUNTER_FREEZE, 8'h01);
      wr(pcb_pkg::COUNTER_FREEZE, 8'h00);
   endtask
   // separate strobes, a refused write and an unmapped odd address
   task automatic t_refuse;
      sty <= 1'b0;
      wr(pcb_pkg::COUNTER_BYTE_HOLDING, 8'hAA);
      rd(1'b1, pcb_pkg::COUNTER_BYTE_HOLDING, 8'h06);
      rd(1'b1, 12'h0FF, pcb_pkg::UNMAPPED_READ);
      rd(1'b1, pcb_pkg::COUNTER_FREEZE, 8'h00);
   endtask
   task automatic wrap_up;
      if (n_fail == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // stimulus
   initial begin
      srst = 1'b1;
      sty = 1'b0;
      ev = 11'h000;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_map();
      t_low_first();
      t_burst();
      t_refuse();
      wrap_up();
   end
   // watchdog
   initial begin
      #(25 * 5000);
      n_fail++;
      wrap_up();
   end
endmodule
